// ### ipr_pkg.sv
// Shared constants and carrier types for the interrupt priority resolver.
// Assumes one 10 MHz clock and an active-low asynchronous reset.
package ipr_pkg;
  localparam int IPR_NSRC = 8;
  localparam int IPR_PRIO_W = 3;
  localparam logic [2:0] IPR_THR_RST = 3'h7;
  localparam logic [2:0] IPR_PRIO_LOWEST = 3'h7;
  // Source index doubles as the fixed default ranking, zero ranks highest
  localparam logic [2:0] IPR_SRC_TMR = 3'h0;
  localparam logic [2:0] IPR_SRC_SRX = 3'h1;
  localparam logic [2:0] IPR_SRC_STX = 3'h2;
  localparam logic [2:0] IPR_SRC_EXT4 = 3'h3;
  localparam logic [2:0] IPR_SRC_EXT0 = 3'h4;
  localparam logic [2:0] IPR_SRC_EXT1 = 3'h5;
  localparam logic [2:0] IPR_SRC_EXT2 = 3'h6;
  localparam logic [2:0] IPR_SRC_EXT3 = 3'h7;
  localparam logic [7:0] IPR_TYPE_TMR0 = 8'h08;
  localparam logic [7:0] IPR_TYPE_TMR1 = 8'h12;
  localparam logic [7:0] IPR_TYPE_TMR2 = 8'h13;
  localparam logic [7:0] IPR_TYPE_SRX = 8'h14;
  localparam logic [7:0] IPR_TYPE_STX = 8'h15;
  localparam logic [7:0] IPR_TYPE_EXT4 = 8'h11;
  localparam logic [7:0] IPR_TYPE_EXT0 = 8'h0c;
  localparam logic [7:0] IPR_TYPE_EXT1 = 8'h0d;
  localparam logic [7:0] IPR_TYPE_EXT2 = 8'h0e;
  localparam logic [7:0] IPR_TYPE_EXT3 = 8'h0f;

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0][2:0] prio;
    logic [1:0] cas_en;
    logic [1:0] sfnm_en;
  } ipr_cfg_t;

  typedef struct packed {
    logic valid;
    logic [2:0] idx;
  } ipr_win_t;
endpackage : ipr_pkg

// ### ipr_timer_status.sv
// Second-level status for the three timers behind the shared input.
// Assumes event pulses and an acknowledge pulse in the clock domain.
`timescale 1ns/1ns
module ipr_timer_status
  import ipr_pkg::*;
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [2:0] evt_i,
  input wire logic ack_i,
  output logic [2:0] status_o,
  output logic pend_o,
  output logic [1:0] sel_o
);
  logic [2:0] status;
  logic [2:0] clr;
  logic [2:0] next_status;

  // Timer 0 outranks timer 1, which outranks timer 2
  assign sel_o = status[0] ? 2'h0 : (status[1] ? 2'h1 : 2'h2);
  assign clr = ack_i ? (3'h1 << sel_o) : 3'h0;
  // New events win over the clear in the same cycle
  assign next_status = (status & ~clr) | evt_i;
  // Shared request stays up while any status bit remains
  assign pend_o = |status;
  assign status_o = status;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status <= 3'h0;
    end else begin
      status <= next_status;
    end
  end

  AST_TMR_KEEP: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    ack_i && ($countones(status) > 1) |=> pend_o)
    else $error("Shared timer request dropped with timers still pending");
  AST_TMR_ONLY: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    ack_i && (evt_i == 3'h0) |=> $countones(status) == $countones($past(status)) - 1)
    else $error("Timer acknowledge did not clear exactly one status bit");
endmodule : ipr_timer_status

// ### ipr_resolve.sv
// Combinational priority resolution over all pending sources.
// Assumes registered request, in-service and configuration inputs.
`timescale 1ns/1ns
module ipr_resolve
  import ipr_pkg::*;
#(
  parameter int NSRC = IPR_NSRC
) (
  input wire logic [NSRC-1:0] req_i,
  input wire logic [NSRC-1:0] mask_i,
  input wire logic [NSRC-1:0][2:0] prio_i,
  input wire logic [2:0] thr_i,
  input wire logic [NSRC-1:0] insvc_i,
  input wire logic [NSRC-1:0] self_ok_i,
  output ipr_win_t win_o
);
  logic [NSRC-1:0] qual;
  logic any_svc;
  logic [2:0] min_svc;
  logic [2:0] best;

  always_comb begin
    any_svc = 1'b0;
    min_svc = IPR_PRIO_LOWEST;
    for (int i = 0; i < NSRC; i++) begin
      if (insvc_i[i] && (prio_i[i] <= min_svc)) begin
        min_svc = prio_i[i];
      end
      any_svc = any_svc | insvc_i[i];
    end
  end

  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      qual[i] = req_i[i] && !mask_i[i]
        && (prio_i[i] <= thr_i)
        && (!insvc_i[i] || self_ok_i[i])
        && (!any_svc || (prio_i[i] <= min_svc));
    end
  end

  // Descending scan with <= lets the lower index win a tie
  always_comb begin
    win_o = '0;
    best = IPR_PRIO_LOWEST;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (qual[i] && (!win_o.valid || (prio_i[i] <= best))) begin
        win_o.valid = 1'b1;
        win_o.idx = i[2:0];
        best = prio_i[i];
      end
    end
  end
endmodule : ipr_resolve

// ### ipr_irq_resolver.sv
// Interrupt priority resolver: pending, in-service, cascade pins, CPU request.
// Assumes synchronous event inputs, CPU acknowledge and end-of-interrupt pulses.
`timescale 1ns/1ns
module ipr_irq_resolver
  import ipr_pkg::*;
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire ipr_cfg_t cfg_i,
  input wire logic thr_wr_i,
  input wire logic [2:0] thr_data_i,
  input wire logic [2:0] tmr_evt_i,
  input wire logic serial_rx_evt_i,
  input wire logic serial_tx_evt_i,
  input wire logic ext_irq_in_four_i,
  input wire logic ext_irq_in_zero_i,
  input wire logic ext_irq_in_one_i,
  input wire logic ext_irq_in_two_i,
  input wire logic ext_irq_in_three_i,
  input wire logic cpu_ack_i,
  input wire logic eoi_i,
  input wire logic [2:0] eoi_src_i,
  output logic cpu_irq_o,
  output logic [7:0] int_type_o,
  output logic int_type_valid_o,
  output logic int_type_ext_o,
  output logic [2:0] thr_o,
  output logic [7:0] req_o,
  output logic [7:0] insvc_o,
  output logic [2:0] tmr_status_o,
  output logic cascade_ack_out_zero_n_o,
  output logic cascade_ack_out_zero_oe_o,
  output logic cascade_ack_out_one_n_o,
  output logic cascade_ack_out_one_oe_o
);
  logic [7:0] req;
  logic [7:0] insvc;
  logic [2:0] thr;
  logic cpu_irq;
  logic [7:0] int_type;
  logic int_type_valid;
  logic int_type_ext;
  logic ack0_n;
  logic ack1_n;
  logic ack0_oe;
  logic ack1_oe;

  ipr_win_t win;
  logic ack_fire;
  logic tmr_ack;
  logic tmr_pend;
  logic [1:0] tmr_sel;
  logic [2:0] tmr_left;
  logic [7:0] evt;
  logic [7:0] self_ok;
  logic [7:0] ack_onehot;
  logic [7:0] eoi_onehot;
  logic [7:0] next_req;
  logic [7:0] next_insvc;
  logic [7:0] tmr_type;
  logic [7:0] fix_type;
  logic [7:0] win_type;
  logic win_casc;
  logic next_cpu_irq;
  logic next_ack0_n;
  logic next_ack1_n;

  // Acknowledge only acts when something qualifies at that moment
  assign ack_fire = cpu_ack_i && win.valid;
  assign tmr_ack = ack_fire && (win.idx == IPR_SRC_TMR);

  // Event vector; pins two and three stop requesting in cascade mode
  assign evt[IPR_SRC_TMR] = |tmr_evt_i;
  assign evt[IPR_SRC_SRX] = serial_rx_evt_i;
  assign evt[IPR_SRC_STX] = serial_tx_evt_i;
  assign evt[IPR_SRC_EXT4] = ext_irq_in_four_i;
  assign evt[IPR_SRC_EXT0] = ext_irq_in_zero_i;
  assign evt[IPR_SRC_EXT1] = ext_irq_in_one_i;
  assign evt[IPR_SRC_EXT2] = ext_irq_in_two_i && !cfg_i.cas_en[0];
  assign evt[IPR_SRC_EXT3] = ext_irq_in_three_i && !cfg_i.cas_en[1];

  // Self preemption only for inputs zero and one, cascade or not
  assign self_ok = {2'h0, cfg_i.sfnm_en, 4'h0};

  assign ack_onehot = ack_fire ? (8'h01 << win.idx) : 8'h00;
  assign eoi_onehot = eoi_i ? (8'h01 << eoi_src_i) : 8'h00;

  ipr_timer_status u_tmr (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .evt_i(tmr_evt_i),
    .ack_i(tmr_ack),
    .status_o(tmr_status_o),
    .pend_o(tmr_pend),
    .sel_o(tmr_sel)
  );

  ipr_resolve #(
    .NSRC(IPR_NSRC)
  ) u_res (
    .req_i(req),
    .mask_i(cfg_i.mask),
    .prio_i(cfg_i.prio),
    .thr_i(thr),
    .insvc_i(insvc),
    .self_ok_i(self_ok),
    .win_o(win)
  );

  // Timer status as it will stand after this edge's shared acknowledge
  assign tmr_left = tmr_status_o & ~(tmr_ack ? (3'h1 << tmr_sel) : 3'h0);

  // Pending bits: a new event beats the acknowledge clear
  always_comb begin
    next_req = (req & ~ack_onehot) | evt;
    // Shared bit follows the leftover status, so it drops with the last timer
    next_req[IPR_SRC_TMR] = (|tmr_left) || (|tmr_evt_i);
  end

  // In-service: acknowledge set beats a same-cycle end-of-interrupt
  assign next_insvc = (insvc & ~eoi_onehot) | ack_onehot;

  // Each timer carries its own vector
  assign tmr_type = (tmr_sel == 2'h0) ? IPR_TYPE_TMR0 :
                    (tmr_sel == 2'h1) ? IPR_TYPE_TMR1 : IPR_TYPE_TMR2;

  always_comb begin
    unique case (win.idx)
      IPR_SRC_TMR: fix_type = tmr_type;
      IPR_SRC_SRX: fix_type = IPR_TYPE_SRX;
      IPR_SRC_STX: fix_type = IPR_TYPE_STX;
      IPR_SRC_EXT4: fix_type = IPR_TYPE_EXT4;
      IPR_SRC_EXT0: fix_type = IPR_TYPE_EXT0;
      IPR_SRC_EXT1: fix_type = IPR_TYPE_EXT1;
      IPR_SRC_EXT2: fix_type = IPR_TYPE_EXT2;
      IPR_SRC_EXT3: fix_type = IPR_TYPE_EXT3;
    endcase
  end
  assign win_type = fix_type;

  // Cascaded sources are flagged on int_type_ext_o; int_type_o still carries their fixed type
  assign win_casc = ((win.idx == IPR_SRC_EXT0) && cfg_i.cas_en[0])
                 || ((win.idx == IPR_SRC_EXT1) && cfg_i.cas_en[1]);

  // Dropped during acknowledge so the CPU does not see a stale request
  assign next_cpu_irq = win.valid && !cpu_ack_i;

  assign next_ack0_n = !(ack_fire && (win.idx == IPR_SRC_EXT0) && cfg_i.cas_en[0]);
  assign next_ack1_n = !(ack_fire && (win.idx == IPR_SRC_EXT1) && cfg_i.cas_en[1]);

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req <= 8'h00;
      insvc <= 8'h00;
    end else begin
      req <= next_req;
      insvc <= next_insvc;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      thr <= IPR_THR_RST;
    end else if (thr_wr_i) begin
      thr <= thr_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cpu_irq <= 1'b0;
      int_type <= 8'h00;
      int_type_valid <= 1'b0;
      int_type_ext <= 1'b0;
    end else begin
      cpu_irq <= next_cpu_irq;
      int_type_valid <= ack_fire;
      if (ack_fire) begin
        int_type <= win_type;
        int_type_ext <= win_casc;
      end
    end
  end

  // Pins stay inputs after reset until cascade is configured
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack0_n <= 1'b1;
      ack1_n <= 1'b1;
      ack0_oe <= 1'b0;
      ack1_oe <= 1'b0;
    end else begin
      ack0_n <= next_ack0_n;
      ack1_n <= next_ack1_n;
      ack0_oe <= cfg_i.cas_en[0];
      ack1_oe <= cfg_i.cas_en[1];
    end
  end

  assign cpu_irq_o = cpu_irq;
  assign int_type_o = int_type;
  assign int_type_valid_o = int_type_valid;
  assign int_type_ext_o = int_type_ext;
  assign thr_o = thr;
  assign req_o = req;
  assign insvc_o = insvc;
  assign cascade_ack_out_zero_n_o = ack0_n;
  assign cascade_ack_out_zero_oe_o = ack0_oe;
  assign cascade_ack_out_one_n_o = ack1_n;
  assign cascade_ack_out_one_oe_o = ack1_oe;

  AST_PEND_SET: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    ext_irq_in_zero_i |=> req[IPR_SRC_EXT0])
    else $error("Input zero event did not set its pending bit");

  AST_MASK_ALL: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (cfg_i.mask == 8'hff) |=> !cpu_irq_o)
    else $error("CPU request raised with every source masked");

  AST_THR_GATE: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    win.valid |-> cfg_i.prio[win.idx] <= thr)
    else $error("Winner priority fails the threshold");

  AST_SELF_BLOCK: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    win.valid && insvc[win.idx] |-> self_ok[win.idx])
    else $error("In-service source chosen outside special nested mode");

  AST_ACK_SVC: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    ack_fire |=> int_type_valid_o && insvc[$past(win.idx)])
    else $error("Acknowledge did not set in-service or present a type");

  AST_ACK_CLR: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    ack_fire && (win.idx != IPR_SRC_TMR) && !evt[win.idx] |=> !req[$past(win.idx)])
    else $error("Acknowledge did not clear the pending bit");

  AST_EOI_CLR: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    eoi_i && !(ack_fire && (win.idx == eoi_src_i)) |=> !insvc[$past(eoi_src_i)])
    else $error("End-of-interrupt did not clear in-service");

  AST_IRQ_DROP: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !win.valid |=> !cpu_irq_o)
    else $error("CPU request held with nothing qualifying");

  AST_CAS_ACK0: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !cascade_ack_out_zero_n_o |-> $past(ack_fire) && ($past(win.idx) == IPR_SRC_EXT0))
    else $error("Cascade acknowledge zero pulsed without input zero acknowledge");

  AST_PIN_DIR: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    cascade_ack_out_one_oe_o |-> $past(cfg_i.cas_en[1]))
    else $error("Pin three driven without cascade mode");

  AST_TMR_VEC: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    tmr_ack && tmr_status_o[0] |=> int_type_o == IPR_TYPE_TMR0)
    else $error("Timer zero delivered with the wrong vector");

  AST_TMR_MIRROR: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    req[IPR_SRC_TMR] == tmr_pend)
    else $error("Shared timer request out of step with timer status");

  AST_CAS_ACK1: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !cascade_ack_out_one_n_o |-> $past(ack_fire) && ($past(win.idx) == IPR_SRC_EXT1))
    else $error("Cascade acknowledge one pulsed without input one acknowledge");

  AST_CAS_IN2: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    cfg_i.cas_en[0] && !req[IPR_SRC_EXT2] |=> !req[IPR_SRC_EXT2])
    else $error("Input two requested while serving as acknowledge output");

  AST_TMR_BLOCK: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    insvc[IPR_SRC_TMR] |-> !(win.valid && (win.idx == IPR_SRC_TMR)))
    else $error("Timer chosen while the shared timer is in service");

  AST_SFNM_ONLY: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    win.valid && insvc[win.idx] |->
      ((cfg_i.sfnm_en[0] && (win.idx == IPR_SRC_EXT0))
      || (cfg_i.sfnm_en[1] && (win.idx == IPR_SRC_EXT1))))
    else $error("Self preemption outside inputs zero and one");

  AST_ACK_IDLE: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    cpu_ack_i && !win.valid |=> !int_type_valid_o)
    else $error("Type presented for an acknowledge with nothing qualifying");

  AST_IRQ_RAISE: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    win.valid && !cpu_ack_i |=> cpu_irq_o)
    else $error("Qualifying source did not raise the CPU request");
endmodule : ipr_irq_resolver

// ### ipr_cpu_model.sv
// CPU core stand-in: acknowledges a raised request after a set delay.
// Assumes the resolver drops its request in the cycle after an acknowledge.
`timescale 1ns/1ns
module ipr_cpu_model (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic irq_i,
  input wire logic en_i,
  input wire logic [3:0] delay_i,
  output logic ack_o
);
  logic [3:0] wait_cnt;

  // Delay restarts whenever the request falls, so a slow core never acks stale state
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_cnt <= 4'h0;
      ack_o <= 1'b0;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (en_i && irq_i) begin
      ack_o <= (wait_cnt >= delay_i);
      wait_cnt <= wait_cnt + 4'h1;
    end else begin
      wait_cnt <= 4'h0;
    end
  end
endmodule : ipr_cpu_model

// ### ipr_irq_resolver_tb.sv
// Self-checking bench for the interrupt priority resolver.
// Assumes the CPU stand-in acks any raised request; the bench issues end-of-interrupt.
`timescale 1ns/1ns
module ipr_irq_resolver_tb
  import ipr_pkg::*;
;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  ipr_cfg_t cfg;
  logic thr_wr = 1'b0;
  logic [2:0] thr_data = 3'h0;
  logic [2:0] tmr_evt = 3'h0;
  logic [7:0] ev = 8'h00;
  logic end_of_interrupt_cmd = 1'b0;
  logic [2:0] eoi_src = 3'h0;
  logic [3:0] delay = 4'h0;
  logic cpu_ack, cpu_irq, type_valid, type_ext, a0_n, a0_oe, a1_n, a1_oe;
  logic [7:0] int_type, req, insvc;
  logic [2:0] thr, tmr_status;
  int n_errors = 0;
  int num_checks = 0;

  always #50 clock = ~clock;

  ipr_irq_resolver u_ipr_irq_resolver (
    .clock_i(clock), .arst_n_i(arst_n), .cfg_i(cfg), .thr_wr_i(thr_wr),
    .thr_data_i(thr_data), .tmr_evt_i(tmr_evt), .serial_rx_evt_i(ev[1]),
    .serial_tx_evt_i(ev[2]), .ext_irq_in_four_i(ev[3]), .ext_irq_in_zero_i(ev[4]),
    .ext_irq_in_one_i(ev[5]), .ext_irq_in_two_i(ev[6]), .ext_irq_in_three_i(ev[7]),
    .cpu_ack_i(cpu_ack), .eoi_i(end_of_interrupt_cmd), .eoi_src_i(eoi_src), .cpu_irq_o(cpu_irq),
    .int_type_o(int_type), .int_type_valid_o(type_valid), .int_type_ext_o(type_ext),
    .thr_o(thr), .req_o(req), .insvc_o(insvc), .tmr_status_o(tmr_status),
    .cascade_ack_out_zero_n_o(a0_n), .cascade_ack_out_zero_oe_o(a0_oe),
    .cascade_ack_out_one_n_o(a1_n), .cascade_ack_out_one_oe_o(a1_oe)
  );

  ipr_cpu_model u_ipr_cpu_model (
    .clock_i(clock), .arst_n_i(arst_n), .irq_i(cpu_irq), .en_i(1'b1),
    .delay_i(delay), .ack_o(cpu_ack)
  );

  task automatic stop_test();
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] %0t exp %h got %h", $time, exp, got);
      n_errors++;
    end
  endtask : chk

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic pulse(input logic [7:0] v, input logic [2:0] t);
    ev = v;
    tmr_evt = t;
    tick();
    ev = 8'h00;
    tmr_evt = 3'h0;
  endtask : pulse

  task automatic end_irq(input logic [2:0] s);
    end_of_interrupt_cmd = 1'b1;
    eoi_src = s;
    tick();
    end_of_interrupt_cmd = 1'b0;
  endtask : end_irq

  task automatic set_thr(input logic [2:0] v);
    thr_wr = 1'b1;
    thr_data = v;
    tick();
    thr_wr = 1'b0;
  endtask : set_thr

  // Bounded wait for the one-cycle type strobe, then judged in that same cycle
  task automatic wait_ack(input logic [7:0] exp);
    int k;
    k = 0;
    tick();
    while (type_valid !== 1'b1 && k < 40) begin
      tick();
      k++;
    end
    chk(8'h01, {7'h0, type_valid});
    chk(exp, int_type);
  endtask : wait_ack

  task automatic t_reset();
    chk(8'h07, {5'h0, thr});
    chk(8'h03, {4'h0, a0_oe, a1_oe, a0_n, a1_n});
    chk(8'h00, {7'h0, cpu_irq});
  endtask : t_reset

  task automatic t_nest();
    pulse(8'h10, 3'h0);
    chk(8'h10, req);
    wait_ack(IPR_TYPE_EXT0);
    chk(8'h00, {7'h0, type_ext});
    chk(8'h10, insvc);
    chk(8'h00, req);
    pulse(8'h80, 3'h0);
    tick(4);
    chk(8'h80, req);
    chk(8'h00, {7'h0, cpu_irq});
    end_irq(3'h4);
    wait_ack(IPR_TYPE_EXT3);
    end_irq(3'h7);
  endtask : t_nest

  task automatic t_mask();
    cfg.mask = 8'hff;
    pulse(8'h02, 3'h0);
    tick(3);
    chk(8'h02, req);
    chk(8'h00, {7'h0, cpu_irq});
    set_thr(3'h0);
    chk(8'h00, {5'h0, thr});
    cfg.mask = 8'h00;
    tick(4);
    chk(8'h00, {7'h0, cpu_irq});
    set_thr(3'h7);
    wait_ack(IPR_TYPE_SRX);
    end_irq(3'h1);
  endtask : t_mask

  task automatic t_self();
    delay = 4'h3;
    pulse(8'h20, 3'h0);
    wait_ack(IPR_TYPE_EXT1);
    pulse(8'h20, 3'h0);
    tick(4);
    chk(8'h20, req);
    chk(8'h00, {7'h0, cpu_irq});
    cfg.sfnm_en = 2'b10;
    wait_ack(IPR_TYPE_EXT1);
    end_irq(3'h5);
    cfg.sfnm_en = 2'b00;
    tick(2);
    chk(8'h00, insvc);
  endtask : t_self

  task automatic t_timer();
    delay = 4'h0;
    pulse(8'h00, 3'h6);
    chk(8'h06, {5'h0, tmr_status});
    chk(8'h01, req);
    wait_ack(IPR_TYPE_TMR1);
    chk(8'h04, {5'h0, tmr_status});
    chk(8'h01, req);
    pulse(8'h00, 3'h1);
    tick(4);
    chk(8'h05, {5'h0, tmr_status});
    chk(8'h00, {7'h0, cpu_irq});
    end_irq(3'h0);
    wait_ack(IPR_TYPE_TMR0);
    end_irq(3'h0);
    wait_ack(IPR_TYPE_TMR2);
    chk(8'h00, {5'h0, tmr_status});
    chk(8'h00, req);
    end_irq(3'h0);
  endtask : t_timer

  task automatic t_cascade();
    cfg.cas_en = 2'b11;
    tick(2);
    chk(8'h03, {6'h0, a0_oe, a1_oe});
    pulse(8'h40, 3'h0);
    tick(3);
    chk(8'h00, req);
    pulse(8'h10, 3'h0);
    wait_ack(IPR_TYPE_EXT0);
    chk(8'h05, {5'h0, type_ext, a0_n, a1_n});
    end_irq(3'h4);
    pulse(8'h20, 3'h0);
    wait_ack(IPR_TYPE_EXT1);
    chk(8'h06, {5'h0, type_ext, a0_n, a1_n});
    end_irq(3'h5);
    cfg.cas_en = 2'b00;
    tick(2);
    chk(8'h03, {4'h0, a0_oe, a1_oe, a0_n, a1_n});
  endtask : t_cascade

  // Slow core lets later, better sources overtake the first one before acknowledge
  task automatic t_rank();
    delay = 4'h6;
    cfg.prio[2] = 3'h3;
    pulse(8'h80, 3'h0);
    pulse(8'h0c, 3'h0);
    wait_ack(IPR_TYPE_STX);
    wait_ack(IPR_TYPE_EXT4);
    end_irq(3'h3);
    end_irq(3'h2);
    wait_ack(IPR_TYPE_EXT3);
    end_irq(3'h7);
    tick(3);
    chk(8'h00, {7'h0, cpu_irq});
    chk(8'h00, insvc | req);
  endtask : t_rank

  initial begin
    #(100 * 3000);
    n_errors++;
    stop_test();
  end

  initial begin
    cfg = '0;
    for (int i = 0; i < 8; i++) cfg.prio[i] = i[2:0];
    repeat (6) @(posedge clock);
    #1;
    t_reset();
    arst_n = 1'b1;
    tick(2);
    t_nest();
    t_mask();
    t_self();
    t_timer();
    t_cascade();
    t_rank();
    stop_test();
  end
endmodule : ipr_irq_resolver_tb
